// >>> dv/btms_pin_model.sv
// Purpose: end-of-line tester and board strapping driving the pin levels
// Assumes: the lamp ignites IGN_DLY cycles after ignition starts
// Notes: levels change only just after a rising edge
module btms_pin_model #(
   parameter int IGN_DLY = 40
) (
   // clock
   input wire logic clk,
   // levels asked for by the bench, status seen
   input wire btms_pkg::btms_pins_t req,
   input wire btms_pkg::btms_status_t st,
   // pin levels
   output btms_pkg::btms_pins_t pins
);
   timeunit 1ns;
   timeprecision 100ps;
   int n = 0;
   btms_pkg::btms_pins_t req_r = '0;
   logic lit_r = 1'b0;
   // ==========================================================
   // lamp load: never ignites outside ignition, so a skipped phase shows
   always @(posedge clk) begin
      n <= (st.state == btms_pkg::ST_IGNITION) ? n + 1 : 0;
      req_r <= req;
      lit_r <= (n >= IGN_DLY);
   end
   // one driver per field: strapping levels plus the lamp's own answer
   always_comb begin
      pins = req_r;
      pins.ign_done = lit_r;
   end
endmodule : btms_pin_model

// >>> dv/test_btms_sequencer.sv
// Purpose: self-checking bench of the start-up sequencer test features
// Assumes: MS_US of 5, so one ms is 50 cycles
// Notes: normal pre-run is not run to the end, it would cost 31k cycles
module test_btms_sequencer;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic freq = 1'b0;
   btms_pkg::btms_fclass_t cls = btms_pkg::FC_NONE;
   btms_pkg::btms_pins_t r = '0;
   btms_pkg::btms_pins_t pins;
   btms_pkg::btms_status_t st;
   int error_cnt = 0;
   int samples_checked = 0;
   always #50 clk = ~clk;
   btms_sequencer #(.MS_US(5), .PH_W(12)) btms_sequencer_i (.REF_CLK(clk), .RST_B(rst_b),
      .PIN_IN(pins), .FAULT_REQ(freq), .FAULT_CLASS(cls), .STATUS(st));
   btms_pin_model btms_pin_model_i (.clk(clk), .req(r), .st(st), .pins(pins));
   // ==========================================================
   // shared tasks
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic wt(input btms_pkg::btms_state_t s, input int lim, output int c);
      c = 0;
      while (st.state !== s && c < lim) begin
         @(negedge clk);
         c++;
      end
      chk(st.state, s);
   endtask : wt
   task automatic dr(input btms_pkg::btms_pins_t p);
      @(posedge clk);
      r <= p;
      @(negedge clk);
   endtask : dr
   task automatic rst();
      @(posedge clk);
      rst_b <= 1'b0;
      r <= '0;
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
   endtask : rst
   task automatic flt(input btms_pkg::btms_fclass_t k);
      @(posedge clk);
      freq <= 1'b1;
      cls <= k;
      @(posedge clk);
      freq <= 1'b0;
      repeat (3) @(negedge clk);
   endtask : flt
   function automatic btms_pkg::btms_pins_t good(input logic [7:0] code);
      good = '0;
      good.vcc_start = 1'b1;
      good.vcc_uvlo_ok = 1'b1;
      good.lamp2_gnd = 1'b1;
      good.ph_code = code;
   endfunction : good
   // ==========================================================
   // scenarios
   task automatic t_norm();
      btms_pkg::btms_pins_t p;
      int c;
      rst();
      p = good(8'h02);
      p.vcc_start = 1'b0;
      dr(p);
      repeat (300) @(negedge clk);
      chk(st.state, btms_pkg::ST_MONITOR);
      p.vcc_start = 1'b1;
      dr(p);
      wt(btms_pkg::ST_PREHEAT, 3000, c);
      chk({st.ls_check_en, st.hs_check_en}, 2'h2);
      chk({st.gate_en, st.preheat}, 2'h3);
      wt(btms_pkg::ST_IGNITION, 1200, c);
      chk(c >= 950 && c <= 1010, 1'b1);
   endtask : t_norm
   task automatic t_skip();
      btms_pkg::btms_pins_t p;
      int c;
      rst();
      p = good(8'h10);
      p.ph_gnd = 1'b1;
      p.ls_gnd = 1'b1;
      dr(p);
      wt(btms_pkg::ST_SOFTSTART, 2000, c);
      chk({st.ls_check_en, st.hs_check_en}, 2'h0);
      wt(btms_pkg::ST_IGNITION, 600, c);
   endtask : t_skip
   task automatic t_hold();
      btms_pkg::btms_pins_t p;
      int c;
      rst();
      p = good(8'h01);
      p.ph_high = 1'b1;
      dr(p);
      wt(btms_pkg::ST_PREHEAT, 2500, c);
      repeat (2000) @(negedge clk);
      chk(st.state, btms_pkg::ST_PREHEAT);
      p.ph_high = 1'b0;
      dr(p);
      wt(btms_pkg::ST_IGNITION, 600, c);
      chk(c <= 8, 1'b1);
   endtask : t_hold
   task automatic t_open();
      btms_pkg::btms_pins_t p;
      int c;
      rst();
      p = good(8'h01);
      p.vcc_start = 1'b0;
      p.lamp2_gnd = 1'b0;
      p.lamp1_low = 1'b1;
      dr(p);
      repeat (1100) @(negedge clk);
      p.vcc_start = 1'b1;
      dr(p);
      repeat (300) @(negedge clk);
      chk({st.state, st.hs_check_en, st.gate_en}, {btms_pkg::ST_MONITOR, 2'h2});
      p.lamp1_low = 1'b0;
      dr(p);
      wt(btms_pkg::ST_POWERUP, 10, c);
      // open filament again, filter full before the power-up phase ends
      p.lamp1_low = 1'b1;
      dr(p);
      repeat (1100) @(negedge clk);
      flt(btms_pkg::FC_UNDERVOLT);
      chk(st.state, btms_pkg::ST_MONITOR);
   endtask : t_open
   task automatic t_acc();
      btms_pkg::btms_pins_t p;
      int c;
      rst();
      p = good(8'h04);
      p.vcc_start = 1'b0;
      p.run_freq_high = 1'b1;
      p.ph_freq_high = 1'b1;
      p.ls_upper = 1'b1;
      dr(p);
      repeat (10) @(negedge clk);
      p.vcc_start = 1'b1;
      dr(p);
      repeat (300) @(negedge clk);
      chk(st.accel, 1'b1);
      chk(st.state, btms_pkg::ST_MONITOR);
      p.run_freq_high = 1'b0;
      p.ph_freq_high = 1'b0;
      p.ls_upper = 1'b0;
      p.ls_gnd = 1'b1;
      dr(p);
      wt(btms_pkg::ST_PREHEAT, 2000, c);
      chk(st.accel, 1'b1);
      wt(btms_pkg::ST_IGNITION, 600, c);
      chk(c >= 450 && c <= 510, 1'b1);
      wt(btms_pkg::ST_PRERUN, 200, c);
      wt(btms_pkg::ST_RUN, 2200, c);
      chk(c >= 2050 && c <= 2105, 1'b1);
      p.rect_dc_high = 1'b1;
      dr(p);
      wt(btms_pkg::ST_RESTART_WAIT, 2300, c);
      chk(c >= 2000 && c <= 2110, 1'b1);
      chk(st.restart_used, 1'b1);
      p.rect_dc_high = 1'b0;
      dr(p);
      wt(btms_pkg::ST_MONITOR, 10200, c);
      chk(c >= 9900, 1'b1);
      wt(btms_pkg::ST_RUN, 6000, c);
      flt(btms_pkg::FC_NONE);
      chk(st.state, btms_pkg::ST_RUN);
      flt(btms_pkg::FC_SINGLE);
      wt(btms_pkg::ST_LATCHED, 3, c);
      p.vcc_uvlo_ok = 1'b0;
      dr(p);
      wt(btms_pkg::ST_MONITOR, 100, c);
      chk({st.restart_used, st.fault_latched}, 2'h0);
      p.vcc_uvlo_ok = 1'b1;
      dr(p);
      wt(btms_pkg::ST_RUN, 6000, c);
      flt(btms_pkg::FC_AUTO);
      chk({st.state, st.restart_used}, {btms_pkg::ST_RESTART_WAIT, 1'b0});
   endtask : t_acc
   // ==========================================================
   // verdict and run control
   task automatic summarize();
      $display("checked %0d, wrong %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : summarize
   initial begin
      repeat (70000) @(posedge clk);
      error_cnt++;
      summarize();
   end
   initial begin
      t_norm();
      t_skip();
      t_hold();
      t_open();
      t_acc();
      summarize();
   end
endmodule : test_btms_sequencer

// >>> src/btms_min_dur_filter.sv
// Purpose: minimum duration filter on the shared time base
// Assumes: tick is a one cycle pulse
// Notes: counter restarts as soon as the condition drops
module btms_min_dur_filter #(
   parameter int W = 12,
   parameter int LEN = 1
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // condition and time base
   input wire logic cond,
   input wire logic tick,
   input wire logic [5:0] step,
   // result
   output logic hit
);
   if (LEN < 1 || LEN >= (1 << W) - 64) begin : g_bad
      $error("btms_min_dur_filter: LEN does not fit W");
   end
   logic [W-1:0] cnt_r;
   wire [W-1:0] cnt_nxt = !cond ? '0 : (tick && !hit) ? cnt_r + W'(step) : cnt_r;
   assign hit = cnt_r >= W'(LEN);
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         cnt_r <= '0;
      end else begin
         cnt_r <= cnt_nxt;
      end
   end
endmodule : btms_min_dur_filter

// >>> src/btms_pkg.sv
// Purpose: shared constants and types of the ballast test mode sequencer
// Assumes: 10 MHz reference clock, pins already turned into comparator levels
// Notes: times are kept as printed, cycle counts derive from them
// Function
// - preheat time follows the preheat resistor, zero to 2500 ms.
// - grounded preheat pin skips preheat, ignition right after soft start.
// - preheat pin held high keeps the sequencer in preheat.
// - grounded low-side filament pin disables both filament checks.
// - either lamp sense pin grounded disables only the high-side check.
// - acceleration divides preheat by four and ignition timeout by two.
// - acceleration divides pre-run by fifteen and rectifier filter by sixty.
// - acceleration entered when supply rises while both frequency pins high.
// - low-side pin in upper window holds the pre-power-up state.
// - acceleration stays latched after the frequency pins are released.
// - grounding low-side pin starts power-up on the accelerated base.
// - fault class auto, none, undervoltage or single restart picks recovery.
// - single-restart fault allows one restart after a 200 ms delay.
// - supply below start threshold for 1 us blocks power-up.
// - supply below lockout for 5 us powers down and clears latch.
// - lamp sense one current low for 100 us blocks power-up.
// - rectifier effect is a fault only after its filter time.
package btms_pkg;
   // ==========================================================
   // timing
   localparam int CLK_PERIOD_NS = 100;
   localparam int US_NS = 1000;
   localparam int US_CYC = (US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int MS_US = 1000;
   localparam int PREHEAT_MAX_MS = 2500;
   localparam int IGN_TIMEOUT_MS = 237;
   localparam int PRERUN_MS = 625;
   localparam int RECTIFIER_EFFECT_FAULT_MS = 2500;
   localparam int RESTART_MS = 200;
   localparam int SOFTSTART_MS = 10;
   localparam int POWERUP_US = 130;
   localparam int VCC_START_US = 1;
   localparam int UVLO_US = 5;
   localparam int OPEN_FIL_US = 100;
   // preheat code counts 100 ohm steps, 10 ms each
   localparam int PH_MS_PER_CODE = 10;
   localparam logic [7:0] PH_CODE_MAX = 8'(PREHEAT_MAX_MS / PH_MS_PER_CODE);
   localparam logic [11:0] T_IGN = 12'(IGN_TIMEOUT_MS);
   localparam logic [11:0] T_PRERUN = 12'(PRERUN_MS);
   localparam logic [11:0] T_RESTART = 12'(RESTART_MS);
   localparam logic [11:0] T_SOFT = 12'(SOFTSTART_MS);
   localparam logic [11:0] T_POWERUP = 12'(POWERUP_US);
   localparam logic [11:0] PH_STEP_MS = 12'(PH_MS_PER_CODE);
   // ==========================================================
   // acceleration steps per time base tick
   localparam logic [5:0] ACC_NONE = 6'h01;
   localparam logic [5:0] ACC_PH = 6'h04;
   localparam logic [5:0] ACC_IGN = 6'h02;
   localparam logic [5:0] ACC_PRERUN = 6'h0F;
   localparam logic [5:0] ACC_RECTIFIER_EFFECT_FAULT = 6'h3C;
   // ==========================================================
   // types
   typedef enum logic [3:0] {
      ST_MONITOR, ST_POWERUP, ST_SOFTSTART, ST_PREHEAT, ST_IGNITION,
      ST_PRERUN, ST_RUN, ST_RESTART_WAIT, ST_LATCHED
   } btms_state_t;
   typedef enum logic [1:0] {FC_AUTO, FC_NONE, FC_UNDERVOLT, FC_SINGLE} btms_fclass_t;
   typedef struct packed {
      logic vcc_start;
      logic vcc_uvlo_ok;
      logic ph_gnd;
      logic ph_high;
      logic [7:0] ph_code;
      logic ls_gnd;
      logic ls_upper;
      logic lamp1_gnd;
      logic lamp2_gnd;
      logic lamp1_low;
      logic run_freq_high;
      logic ph_freq_high;
      logic rect_dc_high;
      logic ign_done;
   } btms_pins_t;
   typedef struct packed {
      btms_state_t state;
      logic accel;
      logic gate_en;
      logic preheat;
      logic hs_check_en;
      logic ls_check_en;
      logic fault_latched;
      logic restart_used;
   } btms_status_t;
endpackage : btms_pkg

// >>> src/btms_sequencer.sv
// Purpose: start-up sequencer with customer test features
// Assumes: pin levels from comparators, faults from the protection matrix
// Notes: RST_B is the supply lockout reset; acceleration only clears there
module btms_sequencer #(
   parameter int MS_US = btms_pkg::MS_US,
   parameter int PH_W = 12
) (
   // clock and reset
   input wire logic REF_CLK,
   input wire logic RST_B,
   // pin comparator levels, asynchronous
   input wire btms_pkg::btms_pins_t PIN_IN,
   // protection events, same clock
   input wire logic FAULT_REQ,
   input wire btms_pkg::btms_fclass_t FAULT_CLASS,
   // sequencer status
   output btms_pkg::btms_status_t STATUS
);
   if (PH_W != 12) begin : g_bad
      $error("btms_sequencer: phase counter must be 12 bits");
   end

   // ==========================================================
   // functions
   function automatic logic [5:0] phase_step(input btms_pkg::btms_state_t st, input logic acc);
      logic [5:0] s;
      s = btms_pkg::ACC_NONE;
      if (acc) begin
         unique case (st)
            btms_pkg::ST_PREHEAT: s = btms_pkg::ACC_PH;
            btms_pkg::ST_IGNITION: s = btms_pkg::ACC_IGN;
            btms_pkg::ST_PRERUN: s = btms_pkg::ACC_PRERUN;
            btms_pkg::ST_RUN: s = btms_pkg::ACC_RECTIFIER_EFFECT_FAULT;
            default: s = btms_pkg::ACC_NONE;
         endcase
      end
      return s;
   endfunction : phase_step

   function automatic logic [11:0] sat_add(input logic [11:0] a, input logic [5:0] b);
      logic [12:0] s;
      s = {1'b0, a} + 13'(b);
      return s[12] ? 12'hFFF : s[11:0];
   endfunction : sat_add

   // ==========================================================
   // pin synchroniser
   btms_pkg::btms_pins_t pin_m_r;
   btms_pkg::btms_pins_t pin_s_r;
   logic vcc_start_d_r;
   always_ff @(posedge REF_CLK) begin
      if (!RST_B) begin
         pin_m_r <= '0;
         pin_s_r <= '0;
         vcc_start_d_r <= 1'b0;
      end else begin
         pin_m_r <= PIN_IN;
         pin_s_r <= pin_m_r;
         vcc_start_d_r <= pin_s_r.vcc_start;
      end
   end

   // ==========================================================
   // state and time base
   btms_pkg::btms_state_t state_r;
   btms_pkg::btms_state_t state_nxt;
   logic [11:0] ph_cnt_r;
   logic accel_r;
   logic restart_used_r;
   logic restart_used_nxt;
   btms_pkg::btms_status_t status_r;
   logic us_tick;
   logic ms_tick;

   btms_timebase #(
      .US_CYC(btms_pkg::US_CYC),
      .MS_US(MS_US)
   ) u_tb (
      .clk(REF_CLK),
      .rst_b(RST_B),
      .us_tick(us_tick),
      .ms_tick(ms_tick)
   );

   // ==========================================================
   // filament check enables
   wire hs_check_en = !pin_s_r.ls_gnd && !pin_s_r.lamp1_gnd && !pin_s_r.lamp2_gnd;
   wire ls_check_en = !pin_s_r.ls_gnd;

   // ==========================================================
   // minimum duration filters, all on the shared ticks
   logic start_low_hit;
   logic uvlo_hit;
   logic open_hs_hit;
   logic rect_hit;
   wire in_run = state_r == btms_pkg::ST_RUN;
   wire [5:0] rectifier_effect_fault_step = phase_step(btms_pkg::ST_RUN, accel_r);

   btms_min_dur_filter #(
      .W(12),
      .LEN(btms_pkg::VCC_START_US)
   ) u_start_flt (
      .clk(REF_CLK),
      .rst_b(RST_B),
      .cond(!pin_s_r.vcc_start),
      .tick(us_tick),
      .step(btms_pkg::ACC_NONE),
      .hit(start_low_hit)
   );

   btms_min_dur_filter #(
      .W(12),
      .LEN(btms_pkg::UVLO_US)
   ) u_uvlo_flt (
      .clk(REF_CLK),
      .rst_b(RST_B),
      .cond(!pin_s_r.vcc_uvlo_ok),
      .tick(us_tick),
      .step(btms_pkg::ACC_NONE),
      .hit(uvlo_hit)
   );

   btms_min_dur_filter #(
      .W(12),
      .LEN(btms_pkg::OPEN_FIL_US)
   ) u_open_flt (
      .clk(REF_CLK),
      .rst_b(RST_B),
      .cond(pin_s_r.lamp1_low && hs_check_en),
      .tick(us_tick),
      .step(btms_pkg::ACC_NONE),
      .hit(open_hs_hit)
   );

   // a fast step on a slow tick keeps the filter cheap; resolution is 60 ms in test
   btms_min_dur_filter #(
      .W(12),
      .LEN(btms_pkg::RECTIFIER_EFFECT_FAULT_MS)
   ) u_rect_flt (
      .clk(REF_CLK),
      .rst_b(RST_B),
      .cond(pin_s_r.rect_dc_high && in_run),
      .tick(ms_tick),
      .step(rectifier_effect_fault_step),
      .hit(rect_hit)
   );

   // ==========================================================
   // decoding
   wire ph_gnd = pin_s_r.ph_gnd;
   wire ph_high = pin_s_r.ph_high && !ph_gnd;
   wire [7:0] ph_code = pin_s_r.ph_code > btms_pkg::PH_CODE_MAX ? btms_pkg::PH_CODE_MAX : pin_s_r.ph_code;
   wire [11:0] ph_tgt = 12'(ph_code) * btms_pkg::PH_STEP_MS;
   wire [5:0] ph_step = phase_step(state_r, accel_r);
   wire ph_tick = state_r == btms_pkg::ST_POWERUP ? us_tick : ms_tick;
   wire [11:0] ph_cnt_nxt = state_nxt != state_r ? 12'h000 : ph_tick ? sat_add(ph_cnt_r, ph_step) : ph_cnt_r;
   wire active = state_r != btms_pkg::ST_MONITOR && state_r != btms_pkg::ST_RESTART_WAIT
      && state_r != btms_pkg::ST_LATCHED;
   wire fault_ext = FAULT_REQ && FAULT_CLASS != btms_pkg::FC_NONE && active;
   wire ign_timeout = state_r == btms_pkg::ST_IGNITION && ph_cnt_r >= btms_pkg::T_IGN;
   wire fault_single = rect_hit || ign_timeout || (fault_ext && FAULT_CLASS == btms_pkg::FC_SINGLE);
   wire quiet = !uvlo_hit && !fault_ext && !rect_hit;
   // in test mode the tester holds off start through the low-side pin
   wire may_power_up = pin_s_r.vcc_start && pin_s_r.vcc_uvlo_ok && !start_low_hit && !open_hs_hit
      && !pin_s_r.ls_upper && (!accel_r || pin_s_r.ls_gnd);
   wire accel_entry = state_r == btms_pkg::ST_MONITOR && pin_s_r.vcc_start && !vcc_start_d_r
      && pin_s_r.run_freq_high && pin_s_r.ph_freq_high;
   wire gate_on = state_r inside {btms_pkg::ST_SOFTSTART, btms_pkg::ST_PREHEAT,
      btms_pkg::ST_IGNITION, btms_pkg::ST_PRERUN, btms_pkg::ST_RUN};

   // ==========================================================
   // next state
   always_comb begin
      state_nxt = state_r;
      restart_used_nxt = restart_used_r;
      if (uvlo_hit) begin
         state_nxt = btms_pkg::ST_MONITOR;
         restart_used_nxt = 1'b0;
      end else if (active && fault_single) begin
         state_nxt = restart_used_r ? btms_pkg::ST_LATCHED : btms_pkg::ST_RESTART_WAIT;
         restart_used_nxt = 1'b1;
      end else if (fault_ext && FAULT_CLASS == btms_pkg::FC_AUTO) begin
         state_nxt = btms_pkg::ST_RESTART_WAIT;
      end else if (fault_ext && FAULT_CLASS == btms_pkg::FC_UNDERVOLT) begin
         state_nxt = btms_pkg::ST_MONITOR;
      end else begin
         unique case (state_r)
            btms_pkg::ST_MONITOR: begin
               if (may_power_up) begin
                  state_nxt = btms_pkg::ST_POWERUP;
               end
            end
            btms_pkg::ST_POWERUP: begin
               if (ph_cnt_r >= btms_pkg::T_POWERUP) begin
                  state_nxt = btms_pkg::ST_SOFTSTART;
               end
            end
            btms_pkg::ST_SOFTSTART: begin
               if (ph_cnt_r >= btms_pkg::T_SOFT) begin
                  state_nxt = ph_gnd ? btms_pkg::ST_IGNITION : btms_pkg::ST_PREHEAT;
               end
            end
            btms_pkg::ST_PREHEAT: begin
               // a high pin overrides the resistor time entirely
               if (ph_gnd || (!ph_high && ph_cnt_r >= ph_tgt)) begin
                  state_nxt = btms_pkg::ST_IGNITION;
               end
            end
            btms_pkg::ST_IGNITION: begin
               if (pin_s_r.ign_done) begin
                  state_nxt = btms_pkg::ST_PRERUN;
               end
            end
            btms_pkg::ST_PRERUN: begin
               if (ph_cnt_r >= btms_pkg::T_PRERUN) begin
                  state_nxt = btms_pkg::ST_RUN;
               end
            end
            btms_pkg::ST_RESTART_WAIT: begin
               if (ph_cnt_r >= btms_pkg::T_RESTART) begin
                  state_nxt = btms_pkg::ST_MONITOR;
               end
            end
            btms_pkg::ST_RUN, btms_pkg::ST_LATCHED: begin
               state_nxt = state_r;
            end
            default: state_nxt = btms_pkg::ST_MONITOR;
         endcase
      end
   end

   // ==========================================================
   // registers
   always_ff @(posedge REF_CLK) begin
      if (!RST_B) begin
         state_r <= btms_pkg::ST_MONITOR;
         ph_cnt_r <= 12'h000;
         accel_r <= 1'b0;
         restart_used_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         ph_cnt_r <= ph_cnt_nxt;
         accel_r <= accel_r || accel_entry;
         restart_used_r <= restart_used_nxt;
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (!RST_B) begin
         status_r <= '0;
      end else begin
         status_r.state <= state_r;
         status_r.accel <= accel_r;
         status_r.gate_en <= gate_on;
         status_r.preheat <= state_r == btms_pkg::ST_PREHEAT;
         status_r.hs_check_en <= hs_check_en;
         status_r.ls_check_en <= ls_check_en;
         status_r.fault_latched <= state_r == btms_pkg::ST_LATCHED;
         status_r.restart_used <= restart_used_r;
      end
   end
   assign STATUS = status_r;

   // ==========================================================
   // assertions
   default clocking cb @(posedge REF_CLK);
   endclocking
   default disable iff (!RST_B);

   AST_PH_TIME: assert property (
      state_r == btms_pkg::ST_PREHEAT && !ph_high && ph_cnt_r >= ph_tgt && quiet
      |=> state_r == btms_pkg::ST_IGNITION)
      else $error("preheat did not end at its set time");
   AST_SKIP_PH: assert property (
      state_r == btms_pkg::ST_SOFTSTART && ph_cnt_r >= btms_pkg::T_SOFT && ph_gnd && quiet
      |=> state_r == btms_pkg::ST_IGNITION)
      else $error("grounded preheat pin did not skip preheat");
   AST_PH_HOLD: assert property (
      state_r == btms_pkg::ST_PREHEAT && ph_high && quiet |=> state_r == btms_pkg::ST_PREHEAT)
      else $error("preheat left while pin held high");
   AST_FIL_LS: assert property (
      pin_s_r.ls_gnd |=> !status_r.ls_check_en && !status_r.hs_check_en)
      else $error("filament checks active with low-side pin grounded");
   AST_FIL_HS: assert property (
      (pin_s_r.lamp1_gnd || pin_s_r.lamp2_gnd) && !pin_s_r.ls_gnd
      |=> !status_r.hs_check_en && status_r.ls_check_en)
      else $error("lamp sense ground did not disable only the high-side check");
   AST_PH_ACC: assert property (
      state_r == btms_pkg::ST_PREHEAT && state_nxt == state_r && ms_tick && accel_r && ph_cnt_r < 12'hF00
      |=> ph_cnt_r == $past(ph_cnt_r) + 12'h004)
      else $error("accelerated preheat step is not four");
   AST_IGN_ACC: assert property (
      state_r == btms_pkg::ST_IGNITION && state_nxt == state_r && ms_tick && accel_r
      |=> ph_cnt_r == $past(ph_cnt_r) + 12'h002)
      else $error("accelerated ignition step is not two");
   AST_PRERUN_ACC: assert property (
      state_r == btms_pkg::ST_PRERUN && state_nxt == state_r && ms_tick && accel_r
      |=> ph_cnt_r == $past(ph_cnt_r) + 12'h00F)
      else $error("accelerated pre-run step is not fifteen");
   AST_ACC_ENTRY: assert property (
      accel_entry |=> accel_r ##1 status_r.accel)
      else $error("acceleration not entered");
   AST_LS_HOLD: assert property (
      state_r == btms_pkg::ST_MONITOR && pin_s_r.ls_upper && !uvlo_hit |=> state_r == btms_pkg::ST_MONITOR)
      else $error("powered up with low-side pin in upper window");
   AST_ACC_LATCH: assert property (
      accel_r |=> accel_r)
      else $error("acceleration released");
   AST_ACC_START: assert property (
      state_r == btms_pkg::ST_MONITOR && accel_r && !pin_s_r.ls_gnd |=> state_r != btms_pkg::ST_POWERUP)
      else $error("test mode powered up without low-side pin grounded");
   AST_NO_FAULT: assert property (
      in_run && FAULT_REQ && FAULT_CLASS == btms_pkg::FC_NONE && !uvlo_hit && !rect_hit |=> in_run)
      else $error("no-fault event left run");
   AST_LATCH: assert property (
      active && fault_single && restart_used_r && !uvlo_hit |=> state_r == btms_pkg::ST_LATCHED ##1 status_r.fault_latched)
      else $error("second single-restart fault did not latch");
   AST_RESTART: assert property (
      state_r == btms_pkg::ST_RESTART_WAIT && ph_cnt_r >= btms_pkg::T_RESTART && !uvlo_hit
      |=> state_r == btms_pkg::ST_MONITOR)
      else $error("restart not taken after delay");
   AST_START_BLK: assert property (
      state_r == btms_pkg::ST_MONITOR && start_low_hit |=> state_r == btms_pkg::ST_MONITOR)
      else $error("powered up below start threshold");
   AST_UVLO: assert property (
      uvlo_hit |=> state_r == btms_pkg::ST_MONITOR && !restart_used_r)
      else $error("lockout did not power down and clear latch");
   AST_OPEN_HS: assert property (
      state_r == btms_pkg::ST_MONITOR && open_hs_hit |=> state_r == btms_pkg::ST_MONITOR)
      else $error("powered up with open high-side filament");
   AST_RECT: assert property (
      in_run && rect_hit && !uvlo_hit |=> state_r inside {btms_pkg::ST_RESTART_WAIT, btms_pkg::ST_LATCHED})
      else $error("rectifier effect not handled as fault");

   COV_ACCEL: cover property (accel_entry ##1 accel_r);
   COV_PH_IGN: cover property (state_r == btms_pkg::ST_PREHEAT ##1 state_r == btms_pkg::ST_IGNITION);
   COV_RUN: cover property (state_r == btms_pkg::ST_PRERUN ##1 in_run);
   COV_LATCH: cover property (state_r == btms_pkg::ST_LATCHED);
endmodule : btms_sequencer

// >>> src/btms_timebase.sv
// Purpose: shared microsecond and millisecond ticks
// Assumes: one reference clock
// Notes: every phase timer and filter counts these ticks
module btms_timebase #(
   parameter int US_CYC = btms_pkg::US_CYC,
   parameter int MS_US = btms_pkg::MS_US
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // ticks
   output logic us_tick,
   output logic ms_tick
);
   if (US_CYC < 2 || US_CYC > 65535 || MS_US < 1 || MS_US > 65535) begin : g_bad
      $error("btms_timebase: unsupported divider");
   end
   logic [15:0] cyc_r;
   logic [15:0] us_r;
   wire cyc_end = cyc_r == 16'(US_CYC - 1);
   wire us_end = us_r == 16'(MS_US - 1);
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         cyc_r <= 16'h0000;
         us_r <= 16'h0000;
         us_tick <= 1'b0;
         ms_tick <= 1'b0;
      end else begin
         cyc_r <= cyc_end ? 16'h0000 : cyc_r + 16'h0001;
         us_tick <= cyc_end;
         if (cyc_end) begin
            us_r <= us_end ? 16'h0000 : us_r + 16'h0001;
         end
         ms_tick <= cyc_end && us_end;
      end
   end
endmodule : btms_timebase
